/* File: hw/mcrpt_top.sv */
// Clock/reset scheme and one-step PTP transmit trim of a 100G MAC/PCS block.
// Assumes all user inputs except lane clocks and resets are on mclk_i.
//
// Overview of operation
// RULE_01 - One-step timestamp insertion only when enabled; disabled after reset.
// RULE_02 - Transparent-clock select makes timer a correction value, enables correction updates.
// RULE_03 - Transparent mode adds sampled transmit timestamp to packet correction field.
// RULE_04 - User subtracts receive timestamp from correction field before transmit.
// RULE_05 - User supplies timers and reads timestamps in transparent-clock format.
// RULE_06 - Trim offsets one-step timestamp; bits 10:3 ns, bits 2:0 fractional.
// RULE_07 - Trim word resets to 705, the one-step to capture-point delay.
// RULE_08 - User should program trim to 802 in transparent-clock mode.
// RULE_09 - Transceivers supply 322.266 MHz lane receive clocks in both modes.
// RULE_10 - Lane datapath is 32 bits in ten-lane, 80 bits in four-lane mode.
// RULE_11 - One transmit clock runs lane logic, MAC, packet bus, control port.
// RULE_12 - Receive clock is 322.266 MHz and identical to transmit clock.
// RULE_13 - Reconfiguration clock only needed during accesses, up to 250 MHz.
// RULE_14 - All resets held high during configuration until clocks are stable.
// RULE_15 - Receive and transmit reset independently, core and lane logic separately.
// RULE_16 - Resets assert asynchronously and release synchronously via synchronizers.
// RULE_17 - Reset-only controls change only while the matching path is reset.
// RULE_18 - System reset covers everything; datapath resets cover each direction.
// RULE_19 - Optional shared lane clock feeds every lane receive clock input.
// RULE_20 - Runtime-switchable mode uses the ten-lane clock structure.
// RULE_21 - Disabled one-step passes PTP fields untouched and ignores the trim.
`timescale 1ns/1ps
module mcrpt_top
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Path resets, active high, asynchronous
  input wire logic sys_reset_i,
  input wire logic tx_reset_i,
  input wire logic rx_reset_i,
  input wire logic tx_datapath_reset_i,
  input wire logic rx_datapath_reset_i,
  input wire logic [9:0] lane_receive_reset_i,
  // Lane clocks from the transceivers, asynchronous
  input wire logic [9:0] lane_receive_clock_i,
  // Reset-only configuration
  input wire logic one_step_timestamp_enable_i,
  input wire logic transparent_clock_select_i,
  input wire logic [10:0] one_step_latency_trim_i,
  input wire mcrpt_pkg::mcrpt_lane_mode_t lane_mode_i,
  input wire logic shared_lane_clock_i,
  // Transmit timestamp request and result
  input wire logic [63:0] system_timer_i,
  input wire mcrpt_pkg::mcrpt_tx_req_t tx_req_i,
  output logic tx_ready_o,
  output mcrpt_pkg::mcrpt_tx_resp_t tx_resp_o,
  // Status
  output logic tx_path_in_reset_o,
  output logic rx_path_in_reset_o,
  output logic one_step_active_o,
  output logic [9:0] lane_reset_o,
  output logic [6:0] lane_width_o
);

  typedef struct packed
  {
    mcrpt_pkg::mcrpt_tx_state_t state;
    mcrpt_pkg::mcrpt_tx_cfg_t cfg;
    mcrpt_pkg::mcrpt_tx_req_t req;
    mcrpt_pkg::mcrpt_tx_resp_t resp;
    logic [63:0] timer;
    logic ready;
    logic in_reset;
  } mcrpt_tx_st_t;

  typedef struct packed
  {
    logic [9:0] sync1;
    logic [9:0] sync2;
    logic [9:0] prev;
    logic [9:0][3:0] edge_cnt;
    logic [9:0] lane_rst;
    mcrpt_pkg::mcrpt_lane_mode_t mode;
    logic shared;
    logic [6:0] width;
    logic in_reset;
  } mcrpt_rx_st_t;

  function automatic logic lane_active(mcrpt_pkg::mcrpt_lane_mode_t mode, int unsigned n);
    lane_active = (mode != mcrpt_pkg::LANE_MODE_FOUR) || (n < mcrpt_pkg::FOUR_LANES);
  endfunction
  function automatic logic [63:0] trim_to_time(logic [10:0] trim);
    trim_to_time = {40'h0, trim, 13'h0};
  endfunction
  logic tx_rst_n;
  logic rx_rst_n;
  logic [9:0] lane_rst_n;
  mcrpt_tx_st_t tx_q;
  mcrpt_tx_st_t tx_d;
  mcrpt_rx_st_t rx_q;
  mcrpt_rx_st_t rx_d;
  mcrpt_pkg::mcrpt_tx_cfg_t tx_cfg_q;
  logic [2:0] rx_cfg_q;

  // Each path has its own synchronizer; system reset reaches all of them
  mcrpt_reset_sync u_tx_rst // RULE_15
  (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .reset_req_i(sys_reset_i | tx_reset_i | tx_datapath_reset_i), // RULE_18
    .rst_n_o(tx_rst_n)
  );
  mcrpt_reset_sync u_rx_rst
  (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .reset_req_i(sys_reset_i | rx_reset_i | rx_datapath_reset_i), // RULE_18
    .rst_n_o(rx_rst_n)
  );
  for (genvar g = 0; g < mcrpt_pkg::NUM_LANES; g++)
  begin : g_lane_rst
    mcrpt_reset_sync u_lane_rst // RULE_16
    (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .reset_req_i(sys_reset_i | rx_datapath_reset_i | lane_receive_reset_i[g]),
      .rst_n_o(lane_rst_n[g])
    );
  end

  // Transmit side: everything on the one core clock
  always_comb // RULE_11
  begin
    tx_d = tx_q;
    tx_d.cfg = tx_cfg_q; // RULE_01
    tx_d.resp.valid = 1'b0;
    tx_d.in_reset = 1'b0;
    case (tx_q.state)
      mcrpt_pkg::TX_IDLE:
      begin
        if (tx_req_i.valid && tx_q.ready)
        begin
          tx_d.req = tx_req_i;
          tx_d.timer = system_timer_i;
          tx_d.state = mcrpt_pkg::TX_ADD;
        end
      end
      mcrpt_pkg::TX_ADD:
      begin
        tx_d.resp.valid = 1'b1;
        tx_d.resp.modified = 1'b0;
        tx_d.resp.timestamp = tx_q.req.timestamp;
        tx_d.resp.correction = tx_q.req.correction;
        if (tx_q.req.is_ptp && tx_q.cfg.one_step_timestamp_enable) // RULE_01 RULE_21
        begin
          tx_d.resp.modified = 1'b1;
          if (tx_q.cfg.transparent_clock_select) // RULE_02
          begin
            // Timer is the residence correction; trim aligns it to the wire
            tx_d.resp.correction = tx_q.req.correction + tx_q.timer
              + trim_to_time(tx_q.cfg.one_step_latency_trim); // RULE_03 RULE_06
          end
          else
          begin
            tx_d.resp.timestamp = tx_q.timer
              + trim_to_time(tx_q.cfg.one_step_latency_trim); // RULE_06
          end
        end
        tx_d.state = mcrpt_pkg::TX_IDLE;
      end
      default:
      begin
        tx_d.state = mcrpt_pkg::TX_IDLE;
      end
    endcase
    tx_d.ready = (tx_d.state == mcrpt_pkg::TX_IDLE);
  end

  always_ff @(posedge mclk_i or negedge tx_rst_n)
  begin
    if (!tx_rst_n)
    begin
      tx_q <= '0;
      tx_q.state <= mcrpt_pkg::TX_IDLE;
      tx_q.cfg.one_step_latency_trim <= mcrpt_pkg::TRIM_RESET; // RULE_07
      tx_q.in_reset <= 1'b1;
    end
    else
    begin
      tx_q <= tx_d;
    end
  end

  // Receive lanes: sample lane clocks, count edges, hold lanes until stable
  always_comb
  begin
    logic [9:0] rise;
    logic eff;
    rise = rx_q.sync2 & ~rx_q.prev;
    eff = 1'b0;
    rx_d = rx_q;
    rx_d.mode = mcrpt_pkg::mcrpt_lane_mode_t'(rx_cfg_q[2:1]);
    rx_d.shared = rx_cfg_q[0]; // RULE_19
    rx_d.in_reset = 1'b0;
    rx_d.sync1 = lane_receive_clock_i;
    rx_d.sync2 = rx_q.sync1;
    rx_d.prev = rx_q.sync2;
    for (int unsigned n = 0; n < mcrpt_pkg::NUM_LANES; n++)
    begin
      // Shared option: lane 0 clock stands in for every lane
      eff = rx_q.shared ? rise[0] : rise[n]; // RULE_19
      if (!lane_rst_n[n] || !lane_active(rx_q.mode, n))
      begin
        rx_d.edge_cnt[n] = 4'h0;
      end
      else if (eff && (rx_q.edge_cnt[n] != mcrpt_pkg::CLK_STABLE_EDGES))
      begin
        rx_d.edge_cnt[n] = 4'(rx_q.edge_cnt[n] + 4'h1);
      end
      rx_d.lane_rst[n] = (rx_d.edge_cnt[n] != mcrpt_pkg::CLK_STABLE_EDGES);
    end
    // Switchable mode clocks as ten-lane; only four-lane widens the lanes
    rx_d.width = (rx_d.mode == mcrpt_pkg::LANE_MODE_FOUR) ? mcrpt_pkg::LANE_W_FOUR
      : mcrpt_pkg::LANE_W_TEN; // RULE_10 RULE_20
  end

  always_ff @(posedge mclk_i or negedge rx_rst_n)
  begin
    if (!rx_rst_n)
    begin
      rx_q <= '0;
      rx_q.lane_rst <= '1;
      rx_q.width <= mcrpt_pkg::LANE_W_TEN;
      rx_q.in_reset <= 1'b1;
    end
    else
    begin
      rx_q <= rx_d;
    end
  end

  // Reset-only controls: loaded while the path reset is applied
  always_ff @(posedge mclk_i)
  begin
    if (!tx_rst_n)
    begin
      tx_cfg_q <= {one_step_timestamp_enable_i, transparent_clock_select_i,
        one_step_latency_trim_i}; // RULE_17
    end
    if (!rx_rst_n)
    begin
      rx_cfg_q <= {lane_mode_i, shared_lane_clock_i}; // RULE_17
    end
  end

  assign tx_ready_o = tx_q.ready;
  assign tx_resp_o = tx_q.resp;
  assign tx_path_in_reset_o = tx_q.in_reset;
  assign rx_path_in_reset_o = rx_q.in_reset;
  assign one_step_active_o = tx_q.cfg.one_step_timestamp_enable;
  assign lane_reset_o = rx_q.lane_rst;
  assign lane_width_o = rx_q.width;
  // Checks
  a_resp_latency: assert property (@(posedge mclk_i) disable iff (!tx_rst_n) // RULE_11
    (tx_q.ready && tx_req_i.valid) |-> ##2 tx_resp_o.valid)
    else $error("transmit result not two cycles after request");
  a_disabled_pass: assert property (@(posedge mclk_i) disable iff (!tx_rst_n) // RULE_21
    (tx_resp_o.valid && !tx_q.cfg.one_step_timestamp_enable) |->
    (tx_resp_o.timestamp == $past(tx_q.req.timestamp, 1)) && !tx_resp_o.modified)
    else $error("disabled one-step altered a packet");
  a_onestep_ts: assert property (@(posedge mclk_i) disable iff (!tx_rst_n) // RULE_06
    (tx_resp_o.valid && tx_resp_o.modified && !tx_q.cfg.transparent_clock_select) |->
    tx_resp_o.timestamp == $past(tx_q.timer, 1)
    + {40'h0, tx_q.cfg.one_step_latency_trim, 13'h0})
    else $error("one-step timestamp not timer plus trim");
  a_tc_correction: assert property (@(posedge mclk_i) disable iff (!tx_rst_n) // RULE_03
    (tx_resp_o.valid && tx_resp_o.modified && tx_q.cfg.transparent_clock_select) |->
    (tx_resp_o.correction == $past(tx_q.req.correction, 1) + $past(tx_q.timer, 1)
    + {40'h0, tx_q.cfg.one_step_latency_trim, 13'h0}))
    else $error("transparent clock correction not field plus timer plus trim");
  a_ptp_only: assert property (@(posedge mclk_i) disable iff (!tx_rst_n) // RULE_01
    tx_resp_o.modified && tx_resp_o.valid |->
    $past(tx_q.req.is_ptp, 1) && tx_q.cfg.one_step_timestamp_enable)
    else $error("non-PTP packet modified");
  a_cfg_stable: assert property (@(posedge mclk_i) disable iff (!tx_rst_n) // RULE_17
    tx_rst_n && $past(tx_rst_n, 1) |-> $stable(tx_cfg_q))
    else $error("transmit configuration changed outside reset");
  a_lane_width: assert property (@(posedge mclk_i) disable iff (!rx_rst_n) // RULE_10
    ##1 (lane_width_o == ((rx_q.mode == mcrpt_pkg::LANE_MODE_FOUR)
    ? mcrpt_pkg::LANE_W_FOUR : mcrpt_pkg::LANE_W_TEN)))
    else $error("lane width does not match lane mode");
  a_lane_reset: assert property (@(posedge mclk_i) disable iff (!rx_rst_n) // RULE_16
    !lane_rst_n[0] |=> lane_reset_o[0])
    else $error("lane 0 left reset while its reset is applied");
  a_unused_lane: assert property (@(posedge mclk_i) disable iff (!rx_rst_n) // RULE_10
    (rx_q.mode == mcrpt_pkg::LANE_MODE_FOUR) |=> lane_reset_o[9])
    else $error("unused lane released in four-lane mode");
  c_tc_update: cover property (@(posedge mclk_i) disable iff (!tx_rst_n)
    tx_resp_o.valid && tx_resp_o.modified && tx_q.cfg.transparent_clock_select);
  c_onestep_ts: cover property (@(posedge mclk_i) disable iff (!tx_rst_n)
    tx_resp_o.valid && tx_resp_o.modified && !tx_q.cfg.transparent_clock_select);
  c_lane_up: cover property (@(posedge mclk_i) disable iff (!rx_rst_n)
    $fell(lane_reset_o[0]));

endmodule

/* File: hw/mcrpt_pkg.sv */
// Constants and carrier types for the MAC clock/reset and one-step PTP trim block.
// Assumes one core clock; all time values carry 16 fractional nanosecond bits.
package mcrpt_pkg;

  localparam int unsigned NUM_LANES = 10;
  localparam int unsigned FOUR_LANES = 4;
  localparam int unsigned TIME_W = 64;
  localparam int unsigned TRIM_W = 11;
  // Trim [10:3] whole ns, [2:0] fractional ns
  localparam int unsigned TRIM_FRAC_BITS = 3;
  localparam int unsigned TIME_FRAC_BITS = 16;
  localparam int unsigned TRIM_SHIFT = TIME_FRAC_BITS - TRIM_FRAC_BITS;
  localparam logic [10:0] TRIM_RESET = 11'h2c1;
  localparam logic [10:0] TRIM_TRANSPARENT = 11'h322;
  localparam logic [6:0] LANE_W_TEN = 7'h20;
  localparam logic [6:0] LANE_W_FOUR = 7'h50;
  // Lane clock edges seen before a lane leaves reset
  localparam logic [3:0] CLK_STABLE_EDGES = 4'h8;
  localparam int unsigned RESP_LATENCY = 2;

  typedef enum logic [1:0]
  {
    LANE_MODE_TEN = 2'h0,
    LANE_MODE_FOUR = 2'h1,
    LANE_MODE_SWITCH = 2'h2
  } mcrpt_lane_mode_t;

  typedef enum logic [1:0]
  {
    TX_IDLE = 2'h1,
    TX_ADD = 2'h2
  } mcrpt_tx_state_t;

  typedef struct packed
  {
    logic one_step_timestamp_enable;
    logic transparent_clock_select;
    logic [TRIM_W-1:0] one_step_latency_trim;
  } mcrpt_tx_cfg_t;

  typedef struct packed
  {
    logic valid;
    logic is_ptp;
    logic [TIME_W-1:0] timestamp;
    logic [TIME_W-1:0] correction;
  } mcrpt_tx_req_t;

  typedef struct packed
  {
    logic valid;
    logic modified;
    logic [TIME_W-1:0] timestamp;
    logic [TIME_W-1:0] correction;
  } mcrpt_tx_resp_t;

endpackage

/* File: hw/mcrpt_reset_sync.sv */
// Reset synchronizer: asynchronous assertion, two-stage synchronous release.
// Assumes reset_req_i and rstn_i may change at any time relative to mclk_i.
`timescale 1ns/1ps
module mcrpt_reset_sync
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Extra reset request, active high
  input wire logic reset_req_i,
  // Synchronized reset, active low
  output logic rst_n_o
);

  logic arst_n;
  logic stage_q;

  assign arst_n = rstn_i & ~reset_req_i;

  always_ff @(posedge mclk_i or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage_q <= 1'b0;
      rst_n_o <= 1'b0;
    end
    else
    begin
      stage_q <= 1'b1;
      rst_n_o <= stage_q;
    end
  end

endmodule

/* File: dv/mcrpt_lane_model.sv */
// Transceiver stand-in: free lane receive clocks, one gate per lane.
// Assumes the bench gates lanes through run_i; a stopped lane stands low.
`timescale 1ns/1ps
module mcrpt_lane_model
(
  // Lane gates
  input wire logic [9:0] run_i,
  // Lane receive clocks
  output logic [9:0] lane_receive_clock_o
);
  logic ck = 1'b0;
  // Odd start offset keeps lane edges off the mclk grid
  initial
  begin
    #1.3;
    forever #24 ck = ~ck;
  end
  assign lane_receive_clock_o = run_i & {10{ck}};
endmodule

/* File: dv/mcrpt_top_tb.sv */
// Self-checking bench for mcrpt_top: trim arithmetic, lane modes, resets.
// Assumes mcrpt_lane_model supplies the lane clocks.
`timescale 1ns/1ps
module mcrpt_top_tb;
  logic mclk = 1'b0, rstn = 1'b0;
  logic sys_rst = 1'b0, tx_rst = 1'b0, rx_rst = 1'b0;
  logic txd_rst = 1'b0, rxd_rst = 1'b0, shared = 1'b0;
  logic en = 1'b0, tc = 1'b1;
  logic [9:0] lane_rst = 10'h000, lane_clk, run = 10'h3ff;
  logic [10:0] trim = 11'h7ff;
  logic [63:0] timer = 64'h0;
  mcrpt_pkg::mcrpt_lane_mode_t mode = mcrpt_pkg::LANE_MODE_TEN;
  mcrpt_pkg::mcrpt_tx_req_t req = '0;
  mcrpt_pkg::mcrpt_tx_resp_t resp;
  logic ready, tx_in_rst, rx_in_rst, active;
  logic [9:0] lane_out;
  logic [6:0] width;
  int err_count = 0;
  int check_count = 0;

  // One clock for both directions; no reconfiguration accesses, so no port clock
  always #2.5 mclk = ~mclk;

  mcrpt_lane_model mcrpt_lane_model_i (.run_i(run), .lane_receive_clock_o(lane_clk));

  mcrpt_top mcrpt_top_i
  (
    .mclk_i(mclk), .rstn_i(rstn), .sys_reset_i(sys_rst), .tx_reset_i(tx_rst),
    .rx_reset_i(rx_rst), .tx_datapath_reset_i(txd_rst),
    .rx_datapath_reset_i(rxd_rst), .lane_receive_reset_i(lane_rst),
    .lane_receive_clock_i(lane_clk), .one_step_timestamp_enable_i(en),
    .transparent_clock_select_i(tc), .one_step_latency_trim_i(trim),
    .lane_mode_i(mode), .shared_lane_clock_i(shared), .system_timer_i(timer),
    .tx_req_i(req), .tx_ready_o(ready), .tx_resp_o(resp),
    .tx_path_in_reset_o(tx_in_rst), .rx_path_in_reset_o(rx_in_rst),
    .one_step_active_o(active), .lane_reset_o(lane_out), .lane_width_o(width)
  );

  task automatic results();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_ready();
    int n;
    for (n = 0; n < 40 && ready !== 1'b1; n++) @(negedge mclk);
    chk(ready, 1'b1);
  endtask

  task automatic wait_lanes(input logic [9:0] exp);
    int n;
    for (n = 0; n < 300 && lane_out !== exp; n++) @(negedge mclk);
    chk(lane_out, exp);
  endtask

  // Reset-only controls change only under the matching path reset
  task automatic tx_cfg(input logic e, input logic t, input logic [10:0] tr);
    tx_rst = 1'b1;
    en = e;
    tc = t;
    trim = tr;
    repeat (4) @(negedge mclk);
    tx_rst = 1'b0;
    wait_ready();
    chk(tx_in_rst, 1'b0);
    chk(active, e);
  endtask

  // Timer and fields in transparent format when tc is set
  task automatic send(input logic p, input logic [63:0] ts, c, tm);
    wait_ready();
    req = '{1'b1, p, ts, c};
    timer = tm;
    @(negedge mclk);
    req.valid = 1'b0;
    // Result pulse stands only in the cycle after the second edge
    @(negedge mclk);
    chk(resp.valid, 1'b1);
  endtask

  task automatic t_disabled();
    chk(width, mcrpt_pkg::LANE_W_TEN);
    send(1'b1, 64'h0000_0000_1234_0000, 64'h0000_0000_0055_0000, 64'h0000_0009_0000_0000);
    chk(resp.modified, 1'b0);
    chk(resp.timestamp, 64'h0000_0000_1234_0000);
    chk(resp.correction, 64'h0000_0000_0055_0000);
  endtask

  task automatic t_one_step();
    logic [63:0] adj;
    adj = {53'h0, mcrpt_pkg::TRIM_RESET} << mcrpt_pkg::TRIM_SHIFT;
    tx_cfg(1'b1, 1'b0, mcrpt_pkg::TRIM_RESET);
    send(1'b1, 64'h0, 64'h0000_0000_0077_0000, 64'h0000_0001_0000_8000);
    chk(resp.modified, 1'b1);
    chk(resp.timestamp, 64'h0000_0001_0000_8000 + adj);
    chk(resp.correction, 64'h0000_0000_0077_0000);
    send(1'b0, 64'h0000_0000_00aa_0000, 64'h0000_0000_0011_0000, 64'h0000_0002_0000_0000);
    chk(resp.modified, 1'b0);
    chk(resp.timestamp, 64'h0000_0000_00aa_0000);
  endtask

  task automatic t_transparent();
    logic [63:0] adj;
    adj = {53'h0, mcrpt_pkg::TRIM_TRANSPARENT} << mcrpt_pkg::TRIM_SHIFT;
    tx_cfg(1'b1, 1'b1, mcrpt_pkg::TRIM_TRANSPARENT);
    send(1'b1, 64'h0, 64'h0000_0000_0300_0000, 64'h0000_0000_0020_4000);
    chk(resp.modified, 1'b1);
    chk(resp.correction, 64'h0000_0000_0320_4000 + adj);
  endtask

  task automatic rx_cfg(input mcrpt_pkg::mcrpt_lane_mode_t m, input logic s);
    rx_rst = 1'b1;
    mode = m;
    shared = s;
    repeat (4) @(negedge mclk);
    chk(ready, 1'b1);
    rx_rst = 1'b0;
  endtask

  task automatic t_lanes();
    rx_cfg(mcrpt_pkg::LANE_MODE_FOUR, 1'b0);
    wait_lanes(10'h3f0);
    chk(width, mcrpt_pkg::LANE_W_FOUR);
    rx_cfg(mcrpt_pkg::LANE_MODE_SWITCH, 1'b0);
    wait_lanes(10'h000);
    chk(width, mcrpt_pkg::LANE_W_TEN);
    run = 10'h001;
    rx_cfg(mcrpt_pkg::LANE_MODE_TEN, 1'b1);
    wait_lanes(10'h000);
    run = 10'h3ff;
    rx_cfg(mcrpt_pkg::LANE_MODE_TEN, 1'b0);
    wait_lanes(10'h000);
  endtask

  task automatic t_resets();
    lane_rst = 10'h008;
    repeat (4) @(negedge mclk);
    chk(lane_out, 10'h008);
    chk(ready, 1'b1);
    lane_rst = 10'h000;
    wait_lanes(10'h000);
    txd_rst = 1'b1;
    repeat (4) @(negedge mclk);
    chk(ready, 1'b0);
    chk(tx_in_rst, 1'b1);
    chk(rx_in_rst, 1'b0);
    chk(lane_out, 10'h000);
    txd_rst = 1'b0;
    wait_ready();
    rxd_rst = 1'b1;
    repeat (4) @(negedge mclk);
    chk(lane_out, 10'h3ff);
    rxd_rst = 1'b0;
    wait_lanes(10'h000);
    sys_rst = 1'b1;
    #1.1;
    chk(lane_out, 10'h3ff);
    repeat (4) @(negedge mclk);
    chk(ready, 1'b0);
    chk(tx_in_rst, 1'b1);
    chk(rx_in_rst, 1'b1);
    sys_rst = 1'b0;
    wait_ready();
    wait_lanes(10'h000);
  endtask

  initial
  begin
    #200000;
    err_count++;
    results();
  end

  initial
  begin
    repeat (20) @(negedge mclk);
    rstn = 1'b1;
    wait_ready();
    t_disabled();
    t_one_step();
    t_transparent();
    t_lanes();
    t_resets();
    results();
  end
endmodule
